// >>> core/frt_capture_defs.vh
/*
 Constants for the free-running timer and edge capture block:
 register offsets, field positions, reset values and tick counts.
 Assumes an 8-bit register port with byte offsets as printed.
*/
`ifndef FRT_CAPTURE_DEFS_VH
`define FRT_CAPTURE_DEFS_VH

// register offsets
`define OFS_COUNT_LOW        8'h20
`define OFS_COUNT_HIGH       8'h21
`define OFS_CHAN0_RISE       8'h22
`define OFS_CHAN1_RISE       8'h23
`define OFS_CHAN0_FALL       8'h24
`define OFS_CHAN1_FALL       8'h25
`define OFS_CAPTURE_CONFIG   8'h2a
`define OFS_CAPTURE_IRQ_EN   8'h2b
`define OFS_CAPTURE_IRQ_FLAG 8'h2c
`define OFS_TIMER_IRQ_FLAG   8'h2d
`define OFS_TIMER_IRQ_MASK   8'h2e

// capture_config fields
`define CFG_HOLD_FIRST_BIT   7
`define CFG_PRESCALE_MSB     6
`define CFG_PRESCALE_LSB     4
`define CFG_WIDE_BIT         3
`define CFG_WRITABLE_MASK    8'hf8

// capture flag / enable bit positions
`define CAP_C0_RISE          0
`define CAP_C0_FALL          1
`define CAP_C1_RISE          2
`define CAP_C1_FALL          3

// timer flag bit positions
`define TMR_INTERVAL         0
`define TMR_WRAP             1

// reset values
`define RST_BYTE             8'h00
`define RST_NIBBLE           4'h0
`define RST_PAIR             2'h0
`define RST_COUNT            16'h0000

// interval timing in counter ticks
`define INTERVAL_US          1024
`define TICK_MHZ             4
`define INTERVAL_TICKS       (`INTERVAL_US * `TICK_MHZ)
`define INTERVAL_LAST        12'hfff
`define COUNT_LAST           16'hffff

`endif

// >>> core/edge_detect.v
/*
 Rising and falling edge detector for one capture input.
 Assumes the input is already synchronous to clk.
*/
`timescale 1ns/1ps
module edge_detect
(
	input  wire clk,
	input  wire rst,
	input  wire level,
	output wire rise,
	output wire fall
);
	reg prevLevel;

	// previous sample of the input
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			prevLevel <= 1'b0;
		else
			prevLevel <= level;
	end

	// one-cycle pulses on a change
	assign rise = level & ~prevLevel;
	assign fall = ~level & prevLevel;
endmodule

// >>> core/capture_slot.v
/*
 One 8-bit capture timestamp register with hold-first-edge behaviour.
 Assumes load and readAck are one-cycle pulses in the clk domain.
*/
`timescale 1ns/1ps
`include "frt_capture_defs.vh"
module capture_slot
(
	input  wire       clk,
	input  wire       rst,
	input  wire       load,
	input  wire       holdFirst,
	input  wire       readAck,
	input  wire [7:0] loadValue,
	output reg  [7:0] stamp,
	output wire       loaded
);
	reg armed;

	// a held slot ignores edges until software reads it
	assign loaded = load & (~holdFirst | armed);

	// stamp storage and re-arm state
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stamp <= `RST_BYTE;
			armed <= 1'b1;
		end
		else
		begin
			if (loaded)
				stamp <= loadValue;
			// a read re-arms; a load in the same cycle keeps it held
			if (loaded)
				armed <= 1'b0;
			else if (readAck)
				armed <= 1'b1;
		end
	end
endmodule

// >>> core/free_running_timer_edge_capture.v
/*
 Free-running 16-bit timer with edge capture on two inputs, interval
 and wrap interrupts, and an 8-bit register port.
 Assumes all inputs are synchronous to clk; the capture time clock
 arrives as a one-cycle tick enable in the clk domain.
*/
// Added by the designer: strobed register access.
// Notes on behaviour
// - 16-bit counter steps on capture ticks
// - low byte read latches high byte
// - counter write lands with high byte
// - interval interrupt every 4096 counter ticks
// - wrap interrupt on counter overflow
// - two channels, rise and fall stamps
// - edges load matching stamp register
// - hold-first keeps first edge until read
// - prescale n stores counter bits [7+n:n]
// - wide mode chains channel one registers
// - wide mode channel zero stores bits 7:0
// - wide rise loads channel one high byte
// - any stamp load can interrupt
// - enable bits gate four capture sources
// - counter logic runs on clk; capture ticks only enable its steps
// - wide fall loads channel one high byte
// - flags set by edge, write-one clears
`timescale 1ns/1ps
`include "frt_capture_defs.vh"
module free_running_timer_edge_capture
(
	input  wire       clk,
	input  wire       rst,
	input  wire       captureTimeClock,
	input  wire       edgeInputZero,
	input  wire       edgeInputOne,
	input  wire [7:0] address,
	input  wire [7:0] writeData,
	input  wire       writeStrobe,
	input  wire       readStrobe,
	output reg  [7:0] readData,
	output wire       irq
);
	reg  [15:0] count;
	reg  [7:0]  highHold;
	reg  [7:0]  lowWriteHold;
	reg  [7:0]  captureConfig;
	reg  [3:0]  captureIrqEnable;
	reg  [3:0]  captureIrqFlags;
	reg  [1:0]  timerIrqFlags;
	reg  [1:0]  timerIrqMask;
	reg  [15:0] next_count;
	reg  [7:0]  next_readData;
	reg  [7:0]  prescaled;
	reg  [3:0]  next_captureIrqFlags;
	reg  [1:0]  next_timerIrqFlags;

	wire        wrLow;
	wire        wrHigh;
	wire        wrConfig;
	wire        wrIrqEnable;
	wire        wrCapFlags;
	wire        wrTmrFlags;
	wire        wrTmrMask;
	wire        rdLow;
	wire        holdFirst;
	wire        wideMode;
	wire [2:0]  prescale;
	wire        rise0;
	wire        fall0;
	wire        rise1;
	wire        fall1;
	wire [3:0]  slotLoad;
	wire [3:0]  slotRead;
	wire [3:0]  slotLoaded;
	wire [7:0]  stampC0Rise;
	wire [7:0]  stampC0Fall;
	wire [7:0]  stampC1Rise;
	wire [7:0]  stampC1Fall;
	wire [7:0]  lowValue;
	wire [7:0]  ch1RiseValue;
	wire [7:0]  ch1FallValue;
	wire        intervalEvent;
	wire        wrapEvent;
	wire [1:0]  timerEvents;
	wire [3:0]  capClear;
	wire [1:0]  tmrClear;
	wire        capIrq;
	wire        tmrIrq;

	// register port decode
	assign wrLow       = writeStrobe & (address == `OFS_COUNT_LOW);
	assign wrHigh      = writeStrobe & (address == `OFS_COUNT_HIGH);
	assign wrConfig    = writeStrobe & (address == `OFS_CAPTURE_CONFIG);
	assign wrIrqEnable = writeStrobe & (address == `OFS_CAPTURE_IRQ_EN);
	assign wrCapFlags  = writeStrobe & (address == `OFS_CAPTURE_IRQ_FLAG);
	assign wrTmrFlags  = writeStrobe & (address == `OFS_TIMER_IRQ_FLAG);
	assign wrTmrMask   = writeStrobe & (address == `OFS_TIMER_IRQ_MASK);
	assign rdLow       = readStrobe & (address == `OFS_COUNT_LOW);

	// configuration fields
	assign holdFirst = captureConfig[`CFG_HOLD_FIRST_BIT];
	assign wideMode  = captureConfig[`CFG_WIDE_BIT];
	assign prescale  = captureConfig[`CFG_PRESCALE_MSB:`CFG_PRESCALE_LSB];

	// counter next value
	always @*
	begin
		next_count = count;
		if (wrHigh)
			next_count = {writeData, lowWriteHold};
		else if (captureTimeClock)
			next_count = count + 16'h0001;
	end

	// counter register
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			count <= `RST_COUNT;
		else
			count <= next_count;
	end

	// snapshot high byte on low read
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			highHold <= `RST_BYTE;
		else if (rdLow)
			highHold <= count[15:8];
	end

	// low byte parked until high write
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			lowWriteHold <= `RST_BYTE;
		else if (wrLow)
			lowWriteHold <= writeData;
	end

	// interval every INTERVAL_TICKS ticks
	// only the low 12 bits matter, so a counter write re-phases it
	assign intervalEvent = captureTimeClock & ~wrHigh & (count[11:0] == `INTERVAL_LAST);
	assign wrapEvent     = captureTimeClock & ~wrHigh & (count == `COUNT_LAST);
	assign timerEvents   = {wrapEvent, intervalEvent};

	// edge detection on both inputs; the reset level of the
	// previous sample matches the pins' idle low, so no false edge
	edge_detect detectZero
	(
		.clk  (clk),
		.rst  (rst),
		.level(edgeInputZero),
		.rise (rise0),
		.fall (fall0)
	);

	// input one stays watched in wide mode; the routing drops it
	edge_detect detectOne
	(
		.clk  (clk),
		.rst  (rst),
		.level(edgeInputOne),
		.rise (rise1),
		.fall (fall1)
	);

	always @*
	begin
		case (prescale)
			3'h0: prescaled = count[7:0];
			3'h1: prescaled = count[8:1];
			3'h2: prescaled = count[9:2];
			3'h3: prescaled = count[10:3];
			3'h4: prescaled = count[11:4];
			3'h5: prescaled = count[12:5];
			3'h6: prescaled = count[13:6];
			default: prescaled = count[14:7];
		endcase
	end

	assign lowValue = wideMode ? count[7:0] : prescaled;
	assign ch1RiseValue = wideMode ? count[15:8] : prescaled;
	assign ch1FallValue = wideMode ? count[15:8] : prescaled;

	assign slotLoad[`CAP_C0_RISE] = rise0;
	assign slotLoad[`CAP_C0_FALL] = fall0;
	assign slotLoad[`CAP_C1_RISE] = wideMode ? rise0 : rise1;
	assign slotLoad[`CAP_C1_FALL] = wideMode ? fall0 : fall1;

	// a read re-arms only its own slot
	assign slotRead[`CAP_C0_RISE] = readStrobe & (address == `OFS_CHAN0_RISE);
	assign slotRead[`CAP_C0_FALL] = readStrobe & (address == `OFS_CHAN0_FALL);
	assign slotRead[`CAP_C1_RISE] = readStrobe & (address == `OFS_CHAN1_RISE);
	assign slotRead[`CAP_C1_FALL] = readStrobe & (address == `OFS_CHAN1_FALL);

	capture_slot slotC0Rise
	(
		.clk      (clk),
		.rst      (rst),
		.load     (slotLoad[`CAP_C0_RISE]),
		.holdFirst(holdFirst),
		.readAck  (slotRead[`CAP_C0_RISE]),
		.loadValue(lowValue),
		.stamp    (stampC0Rise),
		.loaded   (slotLoaded[`CAP_C0_RISE])
	);

	capture_slot slotC0Fall
	(
		.clk      (clk),
		.rst      (rst),
		.load     (slotLoad[`CAP_C0_FALL]),
		.holdFirst(holdFirst),
		.readAck  (slotRead[`CAP_C0_FALL]),
		.loadValue(lowValue),
		.stamp    (stampC0Fall),
		.loaded   (slotLoaded[`CAP_C0_FALL])
	);

	capture_slot slotC1Rise
	(
		.clk      (clk),
		.rst      (rst),
		.load     (slotLoad[`CAP_C1_RISE]),
		.holdFirst(holdFirst),
		.readAck  (slotRead[`CAP_C1_RISE]),
		.loadValue(ch1RiseValue),
		.stamp    (stampC1Rise),
		.loaded   (slotLoaded[`CAP_C1_RISE])
	);

	capture_slot slotC1Fall
	(
		.clk      (clk),
		.rst      (rst),
		.load     (slotLoad[`CAP_C1_FALL]),
		.holdFirst(holdFirst),
		.readAck  (slotRead[`CAP_C1_FALL]),
		.loadValue(ch1FallValue),
		.stamp    (stampC1Fall),
		.loaded   (slotLoaded[`CAP_C1_FALL])
	);

	// configuration; low three bits are reserved and stay zero
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			captureConfig <= `RST_BYTE;
		else if (wrConfig)
			captureConfig <= writeData & `CFG_WRITABLE_MASK;
	end

	// capture interrupt enables
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			captureIrqEnable <= `RST_NIBBLE;
		else if (wrIrqEnable)
			captureIrqEnable <= writeData[3:0];
	end

	// timer interrupt mask
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			timerIrqMask <= `RST_PAIR;
		else if (wrTmrMask)
			timerIrqMask <= writeData[1:0];
	end

	// write-one clear masks, only during a flag write
	assign capClear = wrCapFlags ? writeData[3:0] : 4'h0;
	assign tmrClear = wrTmrFlags ? writeData[1:0] : 2'h0;

	// set beats write-one clear
	// so an edge landing beside a clear is never lost
	always @*
	begin
		next_captureIrqFlags = (captureIrqFlags & ~capClear) | slotLoaded;
		next_timerIrqFlags   = (timerIrqFlags & ~tmrClear) | timerEvents;
	end

	// sticky flag registers
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			captureIrqFlags <= `RST_NIBBLE;
			timerIrqFlags   <= `RST_PAIR;
		end
		else
		begin
			captureIrqFlags <= next_captureIrqFlags;
			timerIrqFlags   <= next_timerIrqFlags;
		end
	end

	assign capIrq = |(captureIrqFlags & captureIrqEnable);
	// timer events gated by their own mask
	assign tmrIrq = |(timerIrqFlags & timerIrqMask);
	assign irq    = capIrq | tmrIrq;

	// read mux; unmapped offsets read as zero
	// reserved bits of the narrow registers read as zero too
	always @*
	begin
		next_readData = `RST_BYTE;
		if (readStrobe)
		begin
			case (address)
				`OFS_COUNT_LOW:        next_readData = count[7:0];
				`OFS_COUNT_HIGH:       next_readData = highHold;
				`OFS_CHAN0_RISE:       next_readData = stampC0Rise;
				`OFS_CHAN1_RISE:       next_readData = stampC1Rise;
				`OFS_CHAN0_FALL:       next_readData = stampC0Fall;
				`OFS_CHAN1_FALL:       next_readData = stampC1Fall;
				`OFS_CAPTURE_CONFIG:   next_readData = captureConfig;
				`OFS_CAPTURE_IRQ_EN:   next_readData = {4'h0, captureIrqEnable};
				`OFS_CAPTURE_IRQ_FLAG: next_readData = {4'h0, captureIrqFlags};
				`OFS_TIMER_IRQ_FLAG:   next_readData = {6'h00, timerIrqFlags};
				`OFS_TIMER_IRQ_MASK:   next_readData = {6'h00, timerIrqMask};
				default:               next_readData = `RST_BYTE;
			endcase
		end
	end

	// read data valid the cycle after the strobe only
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			readData <= `RST_BYTE;
		else
			readData <= next_readData;
	end
endmodule

// >>> verif/frt_capture_asserts.sv
/*
 Port checker for the timer and capture block.
 Assumes strobes and edge pins are driven right after clk edges.
*/
`timescale 1ns/1ps
module frt_capture_asserts
(
	input logic       clk,
	input logic       rst,
	input logic       edgeInputZero,
	input logic       edgeInputOne,
	input logic [7:0] address,
	input logic [7:0] writeData,
	input logic       writeStrobe,
	input logic       readStrobe,
	input logic [7:0] readData,
	input logic       irq
);
	logic [3:0] capEn;
	logic [1:0] tmrMask;
	logic       wide;
	logic       hold;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// shadow of enable and mode writes
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			capEn <= 4'h0;
			tmrMask <= 2'h0;
			{wide, hold} <= 2'h0;
		end
		else if (writeStrobe)
		begin
			if (address == 8'h2b)
				capEn <= writeData[3:0];
			if (address == 8'h2e)
				tmrMask <= writeData[1:0];
			if (address == 8'h2a)
				{wide, hold} <= {writeData[3], writeData[7]};
		end
	end
	property p_rdIdle; !$past(readStrobe) |-> readData == 8'h00; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
	property p_unmap; readStrobe && address == 8'h30 |=> readData == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_cfgRsvd; readStrobe && address == 8'h2a |=> readData[2:0] == 3'h0; endproperty
	a_cfgRsvd: assert property (p_cfgRsvd) else $error("config low bits set");
	property p_enRsvd; readStrobe && address == 8'h2b |=> readData[7:4] == 4'h0; endproperty
	a_enRsvd: assert property (p_enRsvd) else $error("enable high bits set");
	property p_flagRsvd; readStrobe && address == 8'h2c |=> readData[7:4] == 4'h0; endproperty
	a_flagRsvd: assert property (p_flagRsvd) else $error("flag high bits set");
	property p_rise0; $rose(edgeInputZero) && capEn[0] && !hold |-> ##[1:3] irq; endproperty
	a_rise0: assert property (p_rise0) else $error("no irq after rise");
	property p_rise1; $rose(edgeInputOne) && capEn[2] && !hold && !wide |-> ##[1:3] irq; endproperty
	a_rise1: assert property (p_rise1) else $error("no irq on input one");
	property p_quiet; capEn == 4'h0 && tmrMask == 2'h0 |-> !irq; endproperty
	a_quiet: assert property (p_quiet) else $error("irq while all masked");
	c_irq: cover property ($rose(irq));
	c_high: cover property (readStrobe && address == 8'h21);
	c_wide: cover property ($rose(edgeInputOne) && wide);
endmodule
bind free_running_timer_edge_capture frt_capture_asserts u_chk (.clk(clk), .rst(rst),
	.edgeInputZero(edgeInputZero), .edgeInputOne(edgeInputOne), .address(address),
	.writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
	.readData(readData), .irq(irq));

// >>> verif/edge_source.sv
/*
 Model of the signals on the two capture pins.
 Assumes the bench calls drive from one process.
*/
`timescale 1ns/1ps
module edge_source
(
	input  wire clk,
	output reg  pinZero,
	output reg  pinOne
);
	// pins start low, as after power-up
	initial
	begin
		pinZero = 1'b0;
		pinOne = 1'b0;
	end
	// one level change, then a gap so the stamp lands
	task drive(input logic ch, lv, input int gap = 3);
		@(posedge clk);
		if (ch)
			pinOne <= lv;
		else
			pinZero <= lv;
		repeat (gap) @(posedge clk);
	endtask
endmodule

// >>> verif/free_running_timer_edge_capture_tb.sv
/*
 Bench for the timer and capture block.
 Assumes the edge model drives both capture pins.
*/
`timescale 1ns/1ps
module free_running_timer_edge_capture_tb;
	logic        clk, rst, captureTimeClock, writeStrobe, readStrobe;
	logic [7:0]  address, writeData;
	logic [15:0] t;
	wire  [7:0]  readData;
	wire         irq, pinZero, pinOne;
	int          err_total, check_count;
	logic [7:0]  offs [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h2a, 8'h2b, 8'h30};
	free_running_timer_edge_capture u_dut (.clk(clk), .rst(rst), .captureTimeClock(captureTimeClock),
		.edgeInputZero(pinZero), .edgeInputOne(pinOne), .address(address), .writeData(writeData),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .irq(irq));
	edge_source u_src (.clk(clk), .pinZero(pinZero), .pinOne(pinOne));
	// 25 ns clock
	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	task cmp(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task rd(input logic [7:0] a, exp);
		@(posedge clk);
		address <= a;
		readStrobe <= 1;
		@(posedge clk);
		readStrobe <= 0;
		#1 cmp(readData, exp);
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		address <= a;
		writeData <= d;
		writeStrobe <= 1;
		@(posedge clk);
		writeStrobe <= 0;
	endtask
	// low byte first, high byte commits
	task setc(input logic [15:0] v);
		wr(8'h20, v[7:0]);
		wr(8'h21, v[15:8]);
		t = v;
	endtask
	task tk(input int n);
		repeat (n)
		begin
			@(posedge clk) captureTimeClock <= 1;
			@(posedge clk) captureTimeClock <= 0;
		end
	endtask
	task ci(input logic e);
		@(posedge clk);
		#1 cmp({7'h0, irq}, {7'h0, e});
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard
	initial
	begin
		repeat (30000) @(posedge clk);
		err_total++;
		wrap_up;
	end
	initial
	begin
		{rst, captureTimeClock, writeStrobe, readStrobe} = 4'h8;
		{address, writeData} = 16'h0000;
		repeat (3) @(posedge clk);
		rst <= 0;
		foreach (offs[i]) rd(offs[i], 8'h00);
		$display("done reset");
		setc(16'h12ff);
		rd(8'h20, 8'hff);
		tk(3);
		rd(8'h21, 8'h12);
		rd(8'h20, 8'h02);
		rd(8'h21, 8'h13);
		wr(8'h20, 8'h55);
		rd(8'h20, 8'h02);
		wr(8'h21, 8'haa);
		rd(8'h20, 8'h55);
		rd(8'h21, 8'haa);
		$display("done counter");
		wr(8'h2a, 8'h80);
		setc(16'h0011);
		u_src.drive(0, 1);
		u_src.drive(1, 1, 6);
		setc(16'h0022);
		u_src.drive(0, 0);
		u_src.drive(0, 1);
		u_src.drive(1, 0);
		u_src.drive(1, 1);
		rd(8'h22, 8'h11);
		u_src.drive(0, 0);
		u_src.drive(0, 1);
		rd(8'h22, 8'h22);
		rd(8'h23, 8'h11);
		$display("done hold");
		setc(16'ha5c3);
		wr(8'h2b, 8'h05);
		for (int n = 0; n < 8; n++)
		begin
			wr(8'h2a, {1'b0, n[2:0], 4'h0});
			u_src.drive(0, 0);
			u_src.drive(0, 1);
			u_src.drive(1, 0);
			u_src.drive(1, 1);
			t = 16'ha5c3 >> n;
			rd(8'h22, t[7:0]);
			rd(8'h24, t[7:0]);
			rd(8'h23, t[7:0]);
			rd(8'h25, t[7:0]);
		end
		rd(8'h2c, 8'h0f);
		ci(1);
		wr(8'h2c, 8'h05);
		ci(0);
		rd(8'h2c, 8'h0a);
		wr(8'h2b, 8'h08);
		ci(1);
		wr(8'h2c, 8'h0f);
		ci(0);
		$display("done capture");
		wr(8'h2a, 8'h78);
		setc(16'hbeef);
		u_src.drive(0, 0);
		u_src.drive(0, 1);
		rd(8'h22, 8'hef);
		rd(8'h23, 8'hbe);
		rd(8'h24, 8'hef);
		rd(8'h25, 8'hbe);
		setc(16'h1357);
		u_src.drive(1, 0);
		u_src.drive(1, 1);
		rd(8'h23, 8'hbe);
		rd(8'h25, 8'hbe);
		$display("done wide");
		wr(8'h2b, 8'h00);
		wr(8'h2c, 8'h0f);
		wr(8'h2e, 8'h02);
		setc(16'hfffe);
		tk(1);
		ci(0);
		tk(1);
		ci(1);
		rd(8'h2d, 8'h03);
		wr(8'h2d, 8'h03);
		ci(0);
		setc(16'h1000);
		tk(4095);
		rd(8'h2d, 8'h00);
		tk(1);
		rd(8'h2d, 8'h01);
		ci(0);
		wr(8'h2e, 8'h01);
		ci(1);
		wr(8'h2d, 8'h01);
		ci(0);
		$display("done timer");
		// pins back to idle low, then a second reset mid-run
		u_src.drive(0, 0);
		u_src.drive(1, 0);
		@(posedge clk) rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		foreach (offs[i]) rd(offs[i], 8'h00);
		rd(8'h2c, 8'h00);
		rd(8'h2d, 8'h00);
		ci(0);
		$display("done second reset");
		wrap_up;
	end
endmodule
